// file: rtl/sbt_pkg.sv
// Purpose: Constants for the capture/compare timer block
// Assumes: Avalon-MM slave with 32-bit data, word-aligned registers
// Notes:   Offsets are byte addresses
package sbt_pkg;
    localparam int unsigned CNT_W = 16;
    localparam int unsigned ADDR_W = 5;
    // Register byte offsets
    localparam logic [4:0] OFF_CTL0 = 5'h00; // Count enable, software trigger
    localparam logic [4:0] OFF_CTL1 = 5'h04; // Mode, clock select
    localparam logic [4:0] OFF_OPT0 = 5'h08; // Capture select, overflow
    localparam logic [4:0] OFF_IOC0 = 5'h0c; // Output pin control
    localparam logic [4:0] OFF_CH0_COMPARE_BUFFER = 5'h10; // Channel 0 compare
    localparam logic [4:0] OFF_CH3_COMPARE_BUFFER = 5'h14; // Channel 3 capture/compare
    localparam logic [4:0] OFF_CNT = 5'h18;  // Counter read buffer
    // Field positions
    localparam int unsigned CTL0_CE = 0;
    localparam int unsigned CTL0_EST = 1;
    localparam int unsigned CTL1_EEE = 3;
    localparam int unsigned OPT0_CCS3 = 3;
    localparam int unsigned OPT0_OVF = 0;
    localparam int unsigned IOC_EN0 = 0;
    localparam int unsigned IOC_LV0 = 1;
    localparam int unsigned IOC_EN3 = 6;
    localparam int unsigned IOC_LV3 = 7;
    // Reset values and counter step
    localparam logic [15:0] CNT_IDLE = 16'hffff;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [15:0] CNT_ONE = 16'h0001;
    localparam logic [7:0] IOC_RST = 8'h00;
    localparam logic [2:0] MODE_RST = 3'h0;
    localparam logic [31:0] UNMAPPED = 32'h0000_0000;
    // Operating modes, three-bit field
    typedef enum logic [2:0] {
        MD_INTERVAL = 3'h0,
        MD_EVENT    = 3'h1,
        MD_EXTTRIG  = 3'h2,
        MD_ONESHOT  = 3'h3,
        MD_PWM      = 3'h4,
        MD_FREERUN  = 3'h5,
        MD_PULSEW   = 3'h6,
        MD_RSVD     = 3'h7
    } sbt_mode_t;
endpackage : sbt_pkg

// file: rtl/sbt_timer.sv
// Purpose: 16-bit timer, channel 3 capture/compare, interval mode, outputs
// Assumes: Single 10 MHz clock; pins synchronous to ref_clk
// Notes:   Channels 1 and 2 and the mode sequencers beyond are elsewhere
//
// Notes on behaviour
// R1: Free-running mode: channel 3 capture or compare per its select bit.
// R2: Channel 3 captures in pulse width mode or in free-running with its select bit set, else compares.
// R3: Channel 3 register is 16 bits, read/write while running, reset zero.
// R4: Channel 3 compare value writable while counting is enabled.
// R5: Channel 3 value buffered; counter equal to buffer raises match pulse.
// R6: On channel 3 match, enabled output pin toggles.
// R7: Free-running capture edge latches the counter into channel 3.
// R8: Pulse width capture latches counter and clears counter to zero.
// R9: Read colliding with capture still returns a consistent value.
// R10: Batch write in trigger and PWM modes, anytime elsewhere.
// R11: Counter read buffer is read-only and shows live count when enabled.
// R12: Count disabled: read buffer returns zero, not the idle FFFF.
// R13: Software and external trigger honoured only in trigger and one-shot.
// R14: Software sets channel 0 edge select to none before event count.
// R15: Software selects internal clock for trigger, one-shot, pulse width.
// R16: Interval timer mode is mode field value 000.
// R17: On enable, counter goes FFFF to 0, output 0 toggles, buffer loads.
// R18: Interval match clears counter, toggles output 0, raises match pulse.
// R19: Interval period is channel 0 value plus one count clocks.
// R20: Output 0 is a square wave with half period equal to interval.
// R21: Output control holds per-output enable and idle level bits.
// R22: Channel 0 value zero: match every count clock from the second.
// R23: Channel 0 value FFFF wraps on match without overflow flag.
// R24: Channel 3 below channel 0 matches once per period; above never.
// R25: Counter advances only on an active count clock enable.
`timescale 1ns/100ps
module sbt_timer
    import sbt_pkg::*;
#(
    parameter int unsigned PRESCALE = 1 // Ref clocks per internal count
) (
    input  wire logic               ref_clk,          // 10 MHz clock
    input  wire logic               rst,              // Sync reset, high
    input  wire logic [ADDR_W-1:0]  avs_address,      // Byte address
    input  wire logic               avs_read,         // Read request
    input  wire logic               avs_write,        // Write request
    input  wire logic [31:0]        avs_writedata,    // Write data
    input  wire logic [3:0]         avs_byteenable,   // Byte lanes
    output logic [31:0]             avs_readdata,     // Read data
    output logic                    avs_waitrequest,  // Stall
    input  wire logic               ext_event_in,     // External count event
    input  wire logic               capture_in3_pin,  // Channel 3 capture
    input  wire logic               capture_in0_pin,  // External trigger
    output logic                    timer_out0_pin,   // Channel 0 output
    output logic                    timer_out3_pin,   // Channel 3 output
    output logic                    ch0_match_irq,    // Channel 0 match pulse
    output logic                    ch3_match_irq,    // Channel 3 match pulse
    output logic                    overflow_irq,     // Overflow pulse
    output logic                    trigger_seen      // Valid trigger pulse
);

    logic              ce_q;
    logic              eee_q;
    sbt_mode_t         mode_q;
    logic              ccs3_q;
    logic              ovf_q;
    logic [7:0]        ioc_q;
    logic [CNT_W-1:0]  ch0_compare_buffer_q, ch3_compare_buffer_q, buf0_q, buf3_q, cnt_q;
    logic              ev_d1_q, cap3_d1_q, trg_d1_q;
    logic              started_q, ack_q, out0_q, out3_q;
    logic [15:0]       pre_q;
    logic              tick, wr, start;
    logic              cap3_edge, cap3_mode, match0, match3;
    logic              batch, clr_ovf;

    // Word decode used by several processes
    function automatic logic hit(input logic [4:0] off);
        return avs_address == off;
    endfunction : hit

    assign wr = avs_write && avs_waitrequest == 1'b0 ? 1'b1 : 1'b0;
    assign batch = (mode_q == MD_EXTTRIG) || (mode_q == MD_PWM); // R10

    // Count clock enable: prescaled internal or external edge
    always_ff @(posedge ref_clk) begin
        if (rst || !ce_q || pre_q == 16'(PRESCALE - 1)) begin
            pre_q <= CNT_ZERO;
        end else begin
            pre_q <= pre_q + CNT_ONE;
        end
    end
    assign tick = ce_q && (eee_q ? (ext_event_in && !ev_d1_q)
                               : (pre_q == 16'(PRESCALE - 1))); // R25

    // Edge history of inputs; reset low matches idle pins
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ev_d1_q   <= 1'b0;
            cap3_d1_q <= 1'b0;
            trg_d1_q  <= 1'b0;
        end else begin
            ev_d1_q   <= ext_event_in;
            cap3_d1_q <= capture_in3_pin;
            trg_d1_q  <= capture_in0_pin;
        end
    end
    assign cap3_edge = capture_in3_pin && !cap3_d1_q && ce_q;
    assign cap3_mode = (mode_q == MD_PULSEW) ||
                       (mode_q == MD_FREERUN && ccs3_q); // R1 R2
    assign start = tick && !started_q;
    assign match0 = tick && started_q && cnt_q == buf0_q &&
                    mode_q == MD_INTERVAL; // R18 R19
    assign match3 = tick && started_q && !cap3_mode &&
                    cnt_q == buf3_q; // R5 R24

    // Avalon slave: one wait cycle, then answer
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (avs_read || avs_write) && !ack_q;
        end
    end
    assign avs_waitrequest = (avs_read || avs_write) && !ack_q;

    // Control registers written by software
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ce_q   <= 1'b0;
            eee_q  <= 1'b0; // R15
            mode_q <= sbt_mode_t'(MODE_RST);
            ccs3_q <= 1'b0;
            ioc_q  <= IOC_RST;
        end else if (wr && avs_byteenable[0]) begin
            if (hit(OFF_CTL0)) begin
                ce_q <= avs_writedata[CTL0_CE];
            end
            if (hit(OFF_CTL1)) begin
                mode_q <= sbt_mode_t'(avs_writedata[2:0]); // R16
                eee_q  <= avs_writedata[CTL1_EEE];
            end
            if (hit(OFF_OPT0)) begin
                ccs3_q <= avs_writedata[OPT0_CCS3];
            end
            if (hit(OFF_IOC0)) begin
                ioc_q <= avs_writedata[7:0]; // R21
            end
        end
    end

    // Overflow flag: set wins over software clear
    assign clr_ovf = wr && hit(OFF_OPT0) && avs_byteenable[0] &&
                     !avs_writedata[OPT0_OVF];
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ovf_q <= 1'b0;
        end else if (tick && started_q && cnt_q == CNT_IDLE && !match0) begin
            ovf_q <= 1'b1; // R23
        end else if (clr_ovf) begin
            ovf_q <= 1'b0;
        end
    end

    // Channel 0 compare value
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ch0_compare_buffer_q <= CNT_ZERO;
        end else if (wr && hit(OFF_CH0_COMPARE_BUFFER) && avs_byteenable[1:0] == 2'h3) begin
            ch0_compare_buffer_q <= avs_writedata[15:0];
        end
    end

    // Channel 3: software write or capture; capture wins the cycle
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ch3_compare_buffer_q <= CNT_ZERO; // R3
        end else if (cap3_mode && cap3_edge) begin
            ch3_compare_buffer_q <= cnt_q; // R7 R8
        end else if (wr && hit(OFF_CH3_COMPARE_BUFFER) && avs_byteenable[1:0] == 2'h3) begin
            ch3_compare_buffer_q <= avs_writedata[15:0]; // R3 R4
        end
    end

    // Compare buffers: anytime or batch (at counter clear) loading
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            buf0_q <= CNT_ZERO;
            buf3_q <= CNT_ZERO;
        end else if (start || !batch || match0) begin
            buf0_q <= ch0_compare_buffer_q; // R17 R10
            buf3_q <= ch3_compare_buffer_q; // R5
        end
    end

    // Counter: idles at FFFF, first tick clears it, then counts
    always_ff @(posedge ref_clk) begin
        if (rst || !ce_q) begin
            cnt_q     <= CNT_IDLE;
            started_q <= 1'b0;
        end else if (start) begin
            cnt_q     <= CNT_ZERO; // R17
            started_q <= 1'b1;
        end else if (mode_q == MD_PULSEW && cap3_edge) begin
            cnt_q <= CNT_ZERO; // R8
        end else if (match0) begin
            cnt_q <= CNT_ZERO; // R18 R22 R23
        end else if (tick) begin
            cnt_q <= cnt_q + CNT_ONE; // R25
        end
    end

    // Output flops: toggle when enabled, idle level otherwise
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            out0_q <= 1'b0;
            out3_q <= 1'b0;
        end else begin
            if (!ioc_q[IOC_EN0]) begin
                out0_q <= ioc_q[IOC_LV0]; // R21
            end else if ((start && mode_q == MD_INTERVAL) || match0) begin
                out0_q <= !out0_q; // R17 R18 R20
            end
            if (!ioc_q[IOC_EN3]) begin
                out3_q <= ioc_q[IOC_LV3]; // R21
            end else if (match3) begin
                out3_q <= !out3_q; // R6
            end
        end
    end

    // Registered pin and pulse outputs
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            timer_out0_pin <= 1'b0;
            timer_out3_pin <= 1'b0;
            ch0_match_irq  <= 1'b0;
            ch3_match_irq  <= 1'b0;
            overflow_irq   <= 1'b0;
            trigger_seen   <= 1'b0;
        end else begin
            timer_out0_pin <= out0_q;
            timer_out3_pin <= out3_q;
            ch0_match_irq  <= match0; // R18 R22
            ch3_match_irq  <= match3; // R5
            overflow_irq   <= tick && started_q && cnt_q == CNT_IDLE
                              && !match0; // R23
            // Trigger only counts in the two trigger-driven modes
            trigger_seen <= ce_q && (mode_q == MD_EXTTRIG ||
                            mode_q == MD_ONESHOT) &&
                            ((wr && hit(OFF_CTL0) && avs_byteenable[0] &&
                              avs_writedata[CTL0_EST]) ||
                             (capture_in0_pin && !trg_d1_q)); // R13
        end
    end

    // Read data sampled from flops in the wait cycle; a capture at that same edge is not seen
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            avs_readdata <= UNMAPPED;
        end else if (avs_read && !ack_q) begin
            unique case (avs_address)
                OFF_CTL0: avs_readdata <= {31'h0, ce_q};
                OFF_CTL1: avs_readdata <= {28'h0, eee_q, mode_q};
                OFF_OPT0: avs_readdata <= {28'h0, ccs3_q, 2'h0, ovf_q};
                OFF_IOC0: avs_readdata <= {24'h0, ioc_q};
                OFF_CH0_COMPARE_BUFFER: avs_readdata <= {16'h0, ch0_compare_buffer_q};
                OFF_CH3_COMPARE_BUFFER: avs_readdata <= {16'h0, ch3_compare_buffer_q}; // R9
                OFF_CNT: avs_readdata <= {16'h0,
                            ce_q && started_q ? cnt_q : CNT_ZERO}; // R11 R12
                default: avs_readdata <= UNMAPPED;
            endcase
        end
    end

    // Match on channel 0 always clears counter on the next cycle
    property p_match0_clear;
        @(posedge ref_clk) disable iff (rst)
        match0 && ce_q |=> cnt_q == CNT_ZERO;
    endproperty
    a_match0_clear: assert property (p_match0_clear) // R18
        else $error("counter not cleared after channel 0 match");

    property p_idle_read_zero;
        @(posedge ref_clk) disable iff (rst)
        avs_read && !ack_q && hit(OFF_CNT) && !ce_q
        |=> avs_readdata == 32'h0;
    endproperty
    a_idle_read_zero: assert property (p_idle_read_zero) // R12
        else $error("read buffer not zero while disabled");

    property p_capture3;
        @(posedge ref_clk) disable iff (rst)
        cap3_mode && cap3_edge |=> ch3_compare_buffer_q == $past(cnt_q);
    endproperty
    a_capture3: assert property (p_capture3) // R7
        else $error("channel 3 capture value wrong");

    property p_ch3_toggle;
        @(posedge ref_clk) disable iff (rst)
        match3 && ioc_q[IOC_EN3] && !$changed(ioc_q)
        |=> ##1 timer_out3_pin != $past(timer_out3_pin);
    endproperty
    a_ch3_toggle: assert property (p_ch3_toggle) // R6
        else $error("channel 3 pin did not toggle");

    property p_no_ovf_on_match;
        @(posedge ref_clk) disable iff (rst)
        match0 |=> !overflow_irq && !$rose(ovf_q);
    endproperty
    a_no_ovf_on_match: assert property (p_no_ovf_on_match) // R23
        else $error("overflow raised on channel 0 match");

    property p_start_clear;
        @(posedge ref_clk) disable iff (rst)
        start |=> cnt_q == CNT_ZERO && started_q;
    endproperty
    a_start_clear: assert property (p_start_clear) // R17
        else $error("counter did not start at zero");

    property p_trig_ignored;
        @(posedge ref_clk) disable iff (rst)
        mode_q == MD_INTERVAL && $stable(mode_q) |=> !trigger_seen;
    endproperty
    a_trig_ignored: assert property (p_trig_ignored) // R13
        else $error("trigger honoured in interval mode");

    property p_idle_level;
        @(posedge ref_clk) disable iff (rst)
        !ioc_q[IOC_EN0] ##1 !ioc_q[IOC_EN0] ##1 $stable(ioc_q)
        |=> timer_out0_pin == $past(ioc_q[IOC_LV0], 2);
    endproperty
    a_idle_level: assert property (p_idle_level) // R21
        else $error("disabled output 0 not at idle level");

    // Enabled read of the buffer shows the count of the request cycle
    property p_live_read;
        @(posedge ref_clk) disable iff (rst)
        avs_read && !ack_q && hit(OFF_CNT) && ce_q && started_q
        |=> avs_readdata == {16'h0, $past(cnt_q)};
    endproperty
    a_live_read: assert property (p_live_read) // R11
        else $error("read buffer not showing live count");

    property p_pw_clear;
        @(posedge ref_clk) disable iff (rst)
        mode_q == MD_PULSEW && cap3_edge |=> cnt_q == CNT_ZERO;
    endproperty
    a_pw_clear: assert property (p_pw_clear) // R8
        else $error("pulse width capture did not clear counter");

    // Zero interval: every count clock matches, counter stays at zero
    property p_ch0_every;
        @(posedge ref_clk) disable iff (rst)
        mode_q == MD_INTERVAL && tick && started_q &&
        buf0_q == CNT_ZERO && cnt_q == CNT_ZERO
        |=> ch0_match_irq && cnt_q == CNT_ZERO;
    endproperty
    a_ch0_every: assert property (p_ch0_every) // R22
        else $error("zero interval did not match every count");

endmodule : sbt_timer

// file: verification/sbt_pin_model.sv
// Purpose: Pin-side partner driving capture and trigger inputs
// Assumes: Pins sampled on ref_clk; rising edge is the valid edge
// Notes:   Lines are always driven, so no floating level arises
`timescale 1ns/100ps
module sbt_pin_model (
    input  wire logic ref_clk,         // Timer clock
    output logic      capture_in3_pin, // Channel 3 capture line
    output logic      capture_in0_pin, // External trigger line
    output logic      ext_event_in     // Event line, idle here
);
    // Idle low from time zero, so no spurious edge after reset
    initial begin
        capture_in3_pin = 1'b0;
        capture_in0_pin = 1'b0;
        ext_event_in    = 1'b0;
    end
    // High pulse of w cycles; sel 1 picks capture, 0 picks trigger
    task automatic pulse(input bit sel, input int w);
        @(posedge ref_clk);
        if (sel) begin
            capture_in3_pin <= 1'b1;
        end else begin
            capture_in0_pin <= 1'b1;
        end
        repeat (w) @(posedge ref_clk);
        capture_in3_pin <= 1'b0;
        capture_in0_pin <= 1'b0;
    endtask : pulse
endmodule : sbt_pin_model

// file: verification/sbt_timer_tb_top.sv
// Purpose: Self-checking bench for the capture/compare timer
// Assumes: PRESCALE 1, so one count clock per ref_clk cycle
// Notes:   Pulse windows span whole periods after the start-up edge
`timescale 1ns/100ps
module sbt_timer_tb_top import sbt_pkg::*;;
    logic              ref_clk;
    logic              rst;
    logic [ADDR_W-1:0] avs_address;
    logic              avs_read;
    logic              avs_write;
    logic [31:0]       avs_writedata;
    logic [31:0]       avs_readdata;
    logic              avs_waitrequest;
    logic              cap3, cap0, evt;
    logic              out0, out3, irq0, irq3, trig, ovf;
    int                num_errors, tests_run;
    int                c0, c3, t0, t3, tg, ov;
    logic [31:0]       a, v, b;

    sbt_timer #(.PRESCALE(1)) sbt_timer_i (
        .ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .ext_event_in(evt), .capture_in3_pin(cap3),
        .capture_in0_pin(cap0), .timer_out0_pin(out0),
        .timer_out3_pin(out3), .ch0_match_irq(irq0),
        .ch3_match_irq(irq3), .overflow_irq(ovf), .trigger_seen(trig));
    sbt_pin_model sbt_pin_model_i (.ref_clk(ref_clk),
        .capture_in3_pin(cap3), .capture_in0_pin(cap0),
        .ext_event_in(evt));

    // 10 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    // Hang guard well above the cycle budget
    initial begin
        repeat (20000) @(posedge ref_clk);
        num_errors++;
        complete_run();
    end
    task automatic complete_run;
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : complete_run
    // One access, held until waitrequest is seen low at an edge
    task automatic bus(input bit w, input logic [4:0] adr,
                       input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge ref_clk);
        avs_address   <= adr;
        avs_writedata <= d;
        avs_read      <= !w;
        avs_write     <= w;
        do begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (n >= 20) begin
            num_errors++;
            complete_run();
        end
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    task automatic wr(input logic [4:0] adr, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, adr, d, q);
    endtask : wr
    task automatic rd(input logic [4:0] adr, output logic [31:0] q);
        bus(1'b0, adr, 32'h0, q);
    endtask : rd
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic flag(input string nm, input logic g);
        tests_run++;
        if (g !== 1'b1) begin
            num_errors++;
            $display("[ERR] %s expected 1 seen %b", nm, g);
        end
    endtask : flag
    task automatic rdchk(input logic [4:0] adr, input logic [31:0] e,
                         input string nm);
        logic [31:0] q;
        rd(adr, q);
        chk(nm, e, q);
    endtask : rdchk
    // Count match pulses, trigger pulses and pin toggles over n cycles
    task automatic watch(input int n);
        logic p0, p3;
        c0 = 0;
        c3 = 0;
        t0 = 0;
        t3 = 0;
        tg = 0;
        ov = 0;
        p0 = out0;
        p3 = out3;
        repeat (n) begin
            @(posedge ref_clk);
            c0 += int'(irq0 === 1'b1);
            c3 += int'(irq3 === 1'b1);
            tg += int'(trig === 1'b1);
            ov += int'(ovf === 1'b1);
            t0 += int'(out0 !== p0);
            t3 += int'(out3 !== p3);
            p0 = out0;
            p3 = out3;
        end
    endtask : watch

    // Main sequence
    initial begin
        rst = 1'b1;
        avs_address = '0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = '0;
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        rdchk(OFF_CH3_COMPARE_BUFFER, 32'h0, "ch3_compare_buffer_rst");
        rdchk(OFF_CNT, 32'h0, "cnt_rst");
        rdchk(OFF_IOC0, 32'h0, "ioc0_rst");
        rdchk(5'h1c, 32'h0, "hole_read");
        wr(OFF_CH3_COMPARE_BUFFER, 32'h0000_a5c3);
        rdchk(OFF_CH3_COMPARE_BUFFER, 32'h0000_a5c3, "ch3_compare_buffer_rw");
        wr(OFF_CNT, 32'h0000_1234);
        rdchk(OFF_CNT, 32'h0, "cnt_ro");
        // Outputs disabled: pins sit at their idle levels
        wr(OFF_IOC0, 32'h82);
        repeat (4) @(posedge ref_clk);
        flag("out0_idle", out0);
        flag("out3_idle", out3);
        $display("test registers done");
        // Interval mode, period 4, channel 3 below channel 0
        wr(OFF_IOC0, 32'h41);
        wr(OFF_CTL1, {29'h0, MD_INTERVAL});
        wr(OFF_CH0_COMPARE_BUFFER, 32'h3);
        wr(OFF_CH3_COMPARE_BUFFER, 32'h1);
        wr(OFF_CTL0, 32'h1);
        // Start-up toggle alone, before the first match reaches the pin
        watch(4);
        chk("out0_start", 1, t0);
        watch(40);
        chk("ch0_irqs", 10, c0);
        chk("out0_toggles", 10, t0);
        chk("ch3_irqs", 10, c3);
        chk("out3_toggles", 10, t3);
        chk("no_overflow", 0, ov);
        rd(OFF_CNT, a);
        flag("cnt_live", a < 32'h4);
        wr(OFF_CH3_COMPARE_BUFFER, 32'h5);
        repeat (4) @(posedge ref_clk);
        watch(40);
        chk("ch3_above", 0, c3);
        wr(OFF_CTL0, 32'h0);
        rdchk(OFF_CNT, 32'h0, "cnt_stopped");
        wr(OFF_CH0_COMPARE_BUFFER, 32'h0);
        wr(OFF_CTL0, 32'h1);
        repeat (4) @(posedge ref_clk);
        watch(16);
        chk("ch0_every", 16, c0);
        chk("out0_every", 16, t0);
        rdchk(OFF_CNT, 32'h0, "cnt_held");
        $display("test interval done");
        // Software and pin trigger in modes 0 to 6, all but the reserved one
        for (int m = 0; m < 7; m++) begin
            wr(OFF_CTL0, 32'h0);
            wr(OFF_CTL1, 32'(m));
            wr(OFF_CTL0, 32'h1);
            // Software trigger only counts once counting is enabled
            wr(OFF_CTL0, 32'h3);
            fork
                watch(12);
                sbt_pin_model_i.pulse(1'b0, 2);
            join
            chk("triggers", (m == 2 || m == 3) ? 2 : 0, tg);
        end
        $display("test triggers done");
        // Free-running: capture ignored, then taken with select set
        wr(OFF_CTL0, 32'h0);
        wr(OFF_CTL1, {29'h0, MD_FREERUN});
        wr(OFF_CH3_COMPARE_BUFFER, 32'h1234);
        wr(OFF_CTL0, 32'h1);
        sbt_pin_model_i.pulse(1'b1, 2);
        repeat (4) @(posedge ref_clk);
        rdchk(OFF_CH3_COMPARE_BUFFER, 32'h1234, "compare_keeps");
        wr(OFF_OPT0, 32'h8);
        rd(OFF_CNT, a);
        sbt_pin_model_i.pulse(1'b1, 2);
        rd(OFF_CH3_COMPARE_BUFFER, v);
        rd(OFF_CNT, b);
        flag("cap_window", v > a && v < b);
        fork
            rd(OFF_CH3_COMPARE_BUFFER, a);
            sbt_pin_model_i.pulse(1'b1, 1);
        join
        rd(OFF_CH3_COMPARE_BUFFER, b);
        flag("cap_vs_read", a === v || a === b);
        // Pulse width: capture also clears the counter
        wr(OFF_CTL0, 32'h0);
        wr(OFF_CTL1, {29'h0, MD_PULSEW});
        wr(OFF_CTL0, 32'h1);
        repeat (48) @(posedge ref_clk);
        sbt_pin_model_i.pulse(1'b1, 2);
        rd(OFF_CNT, b);
        rd(OFF_CH3_COMPARE_BUFFER, v);
        flag("pw_capture", v > 32'd40);
        flag("pw_clear", b < 32'd8);
        $display("test capture done");
        complete_run();
    end
endmodule : sbt_timer_tb_top
